/* hdl/rail_sequencer.sv */
// Conversion sequencer and averaging filter for three rails.
// Assumes an analog converter that holds adc_sample valid at the
// last cycle of each conversion window; all inputs synchronous.
// How it works
// - Output moves by difference divided by count
// - Sequence starts at channel 1 shunt
// - Only enabled channel and mode signals convert
// - Linear order; five others before repeat
// - Shunt only: two others before repeat
// - Full sequence lasts three shunt-plus-bus times
// - Shunt and bus times set separately
// - Single signal restarts with no gap
// - Conversion length independent of enables
// - Times span 140 us to 8.244 ms
// - Critical check uses raw conversion
// - Averaging and time fields independent
// - Warning check uses averaged shunt value
// - Reset mode is continuous shunt and bus
`timescale 1ns/1ps
module rail_sequencer #(
    parameter logic [seq_pkg::CTW-1:0] ct_cycles [8] = seq_pkg::CT_CYC
) (
    // Clock, reset, enable
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // Configuration, captured on cfg_wr
    input wire logic cfg_wr,
    input wire logic first_channel_enable,
    input wire logic second_channel_enable,
    input wire logic third_channel_enable,
    input wire logic [2:0] conversion_select_field,
    input wire logic [2:0] sample_weight_field,
    input wire logic [2:0] shunt_conversion_time_field,
    input wire logic [2:0] bus_conversion_time_field,
    // Limits per channel
    input wire logic signed [2:0][seq_pkg::DW-1:0] crit_limit,
    input wire logic signed [2:0][seq_pkg::DW-1:0] warn_limit,
    // Converter side
    input wire logic signed [seq_pkg::DW-1:0] adc_sample,
    output logic conv_start,
    output logic conv_active,
    output logic [2:0] conv_sig,
    // Results and status
    output logic [5:0][seq_pkg::DW-1:0] result,
    output logic [2:0] crit_flag,
    output logic [2:0] warn_flag,
    output logic seq_ready
);
    import seq_pkg::*;

    // First enabled slot after cur, wrap flag on top
    function automatic logic [3:0] next_sig(input logic [2:0] cur,
            input logic [5:0] en);
        logic [3:0] r;
        logic found;
        r = 4'h0;
        found = 1'b0;
        for (int k = 1; k <= NSIG; k++) begin
            if (!found && en[(int'(cur) + k) % NSIG]) begin
                found = 1'b1;
                r[2:0] = 3'((int'(cur) + k) % NSIG);
                r[3] = (int'(cur) + k) >= NSIG;
            end
        end
        return r;
    endfunction

    seq_state_e st_ff, nxt_st;
    logic [2:0] mode_ff, nxt_mode;
    logic [2:0] chen_ff, nxt_chen;
    logic [2:0] wt_ff, nxt_wt;
    logic [2:0] cts_ff, nxt_cts;
    logic [2:0] ctb_ff, nxt_ctb;
    logic single_ff, nxt_single;
    logic [2:0] idx_ff, nxt_idx;
    logic [CTW-1:0] cnt_ff, nxt_cnt;
    logic [CTW-1:0] len_ff, nxt_len;
    logic [5:0][DW-1:0] res_ff, nxt_res;
    logic [2:0] crit_ff, nxt_crit;
    logic [2:0] warn_ff, nxt_warn;
    logic ready_ff, nxt_ready;
    logic start_ff, nxt_start;
    logic [5:0] sig_en;
    logic samp;
    logic [3:0] nx;
    logic [3:0] first;
    logic [3:0] sh;
    logic signed [DW-1:0] old;
    logic signed [DW:0] diff;
    logic signed [DW:0] quot;
    logic signed [DW:0] sum;
    logic [1:0] ch;

    // Per-slot enable from channel enables and mode
    generate
        for (genvar i = 0; i < NSIG; i++) begin : g_en
            assign sig_en[i] = chen_ff[i/2] &&
                mode_ff[(i % 2 == 0) ? MODE_SHUNT_BIT : MODE_BUS_BIT];
        end
    endgenerate

    // Sequencing, averaging and checks
    always_comb begin
        nxt_st = st_ff;
        nxt_mode = mode_ff;
        nxt_chen = chen_ff;
        nxt_wt = wt_ff;
        nxt_cts = cts_ff;
        nxt_ctb = ctb_ff;
        nxt_single = single_ff;
        nxt_idx = idx_ff;
        nxt_cnt = cnt_ff;
        nxt_len = len_ff + CTW'(1);
        nxt_res = res_ff;
        nxt_crit = crit_ff;
        nxt_warn = warn_ff;
        nxt_ready = ready_ff;
        nxt_start = 1'b0;
        samp = (st_ff == st_conv) && (cnt_ff == '0);
        nx = next_sig(idx_ff, sig_en);
        first = next_sig(3'h5, sig_en);
        sh = AVG_SHIFT[wt_ff];
        old = res_ff[idx_ff];
        ch = 2'(idx_ff / 2);
        diff = {adc_sample[DW-1], adc_sample} - {old[DW-1], old};
        quot = diff >>> sh;
        sum = {old[DW-1], old} + quot;
        case (st_ff)
            st_idle: begin
                if ((mode_ff[MODE_CONT_BIT] || single_ff) &&
                        (|sig_en)) begin
                    nxt_st = st_conv;
                    nxt_idx = first[2:0];
                    nxt_cnt = (first[0] ? ct_cycles[ctb_ff]
                        : ct_cycles[cts_ff]) - CTW'(1);
                    nxt_len = '0;
                    nxt_start = 1'b1;
                end
            end
            st_conv: begin
                if (samp) begin
                    nxt_res[idx_ff] = sum[DW-1:0];
                    if (!idx_ff[0]) begin
                        // Limit element selects are unsigned; compare signed
                        nxt_crit[ch] =
                            adc_sample > $signed(crit_limit[ch]);
                        nxt_warn[ch] = $signed(sum[DW-1:0]) >
                            $signed(warn_limit[ch]);
                    end
                    if (nx[3]) begin
                        nxt_ready = 1'b1;
                        nxt_single = 1'b0;
                    end
                    if (nx[3] && !mode_ff[MODE_CONT_BIT]) begin
                        nxt_st = st_idle;
                    end else begin
                        // Next conversion starts at once
                        nxt_idx = nx[2:0];
                        nxt_cnt = (nx[0] ? ct_cycles[ctb_ff]
                            : ct_cycles[cts_ff]) - CTW'(1);
                        nxt_len = '0;
                        nxt_start = 1'b1;
                    end
                end else begin
                    nxt_cnt = cnt_ff - CTW'(1);
                end
            end
            default: nxt_st = st_idle;
        endcase
        // New configuration restarts the sequence
        if (cfg_wr) begin
            nxt_mode = conversion_select_field;
            nxt_chen = {third_channel_enable, second_channel_enable,
                first_channel_enable};
            nxt_wt = sample_weight_field;
            nxt_cts = shunt_conversion_time_field;
            nxt_ctb = bus_conversion_time_field;
            nxt_single = 1'b1;
            nxt_st = st_idle;
            nxt_start = 1'b0;
            if (!(samp && nx[3])) begin
                nxt_ready = 1'b0;
            end
        end
    end

    // State registers
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_ff <= st_idle;
            mode_ff <= MODE_RST;
            chen_ff <= CHEN_RST;
            wt_ff <= WEIGHT_RST;
            cts_ff <= CT_RST;
            ctb_ff <= CT_RST;
            single_ff <= 1'b0;
            idx_ff <= 3'h0;
            cnt_ff <= '0;
            len_ff <= '0;
            res_ff <= '0;
            crit_ff <= 3'h0;
            warn_ff <= 3'h0;
            ready_ff <= 1'b0;
            start_ff <= 1'b0;
        end else if (clk_en) begin
            st_ff <= nxt_st;
            mode_ff <= nxt_mode;
            chen_ff <= nxt_chen;
            wt_ff <= nxt_wt;
            cts_ff <= nxt_cts;
            ctb_ff <= nxt_ctb;
            single_ff <= nxt_single;
            idx_ff <= nxt_idx;
            cnt_ff <= nxt_cnt;
            len_ff <= nxt_len;
            res_ff <= nxt_res;
            crit_ff <= nxt_crit;
            warn_ff <= nxt_warn;
            ready_ff <= nxt_ready;
            start_ff <= nxt_start;
        end
    end

    // Outputs
    assign conv_start = start_ff;
    assign conv_active = (st_ff == st_conv);
    assign conv_sig = idx_ff;
    assign result = res_ff;
    assign crit_flag = crit_ff;
    assign warn_flag = warn_ff;
    assign seq_ready = ready_ff;

    // Checks
    a_avg_unity: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        samp && clk_en && !cfg_wr && sh == 4'h0 |=>
        res_ff[$past(idx_ff)] == $past(adc_sample))
        else $error("unity weight did not load raw sample");

    // Shift kept self-determined so it stays arithmetic
    a_avg_step: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        samp && clk_en |=>
        res_ff[$past(idx_ff)] == DW'($past({old[DW-1], old})
            + $past(diff >>> sh)))
        else $error("average step wrong");

    a_first_shunt: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        st_ff == st_idle && clk_en && !cfg_wr && sig_en[0] &&
        mode_ff[MODE_CONT_BIT] |=> st_ff == st_conv && idx_ff == 3'h0)
        else $error("sequence did not begin at shunt one");

    a_only_enabled: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        conv_active |-> sig_en[idx_ff])
        else $error("disabled signal converted");

    a_linear_order: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        samp && clk_en && !cfg_wr && sig_en == 6'h3F &&
        mode_ff[MODE_CONT_BIT] |=> idx_ff == 3'(($past(idx_ff) + 1) % 6))
        else $error("sequence order broken");

    a_shunt_only: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        samp && clk_en && !cfg_wr && sig_en == 6'h15 && idx_ff == 3'h0
        && mode_ff[MODE_CONT_BIT] |=> idx_ff == 3'h2)
        else $error("shunt only order broken");

    a_no_gap: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        samp && clk_en && !cfg_wr && mode_ff[MODE_CONT_BIT]
        |=> conv_active && conv_start)
        else $error("idle gap between conversions");

    a_conv_len: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        samp |-> len_ff == (idx_ff[0] ? ct_cycles[ctb_ff]
            : ct_cycles[cts_ff]) - CTW'(1))
        else $error("conversion length wrong");

    a_keep_others: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        !samp |=> $stable(res_ff))
        else $error("result changed without conversion");

    a_crit_raw: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        samp && clk_en && !idx_ff[0] |=> crit_ff[$past(ch)] ==
        ($past(adc_sample) > $signed($past(crit_limit[ch]))))
        else $error("critical not raised from raw sample");

    a_warn_avg: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        samp && clk_en && !idx_ff[0] |=>
        warn_ff[$past(ch)] ==
        ($signed(res_ff[$past(idx_ff)]) > $signed($past(warn_limit[ch]))))
        else $error("warning not from averaged value");
endmodule

/* pkg/seq_pkg.sv */
// Constants for the three-rail conversion sequencer.
// Assumes a 125 MHz system clock; times are held in ns.
package seq_pkg;
    // Clock
    localparam int CLK_NS = 8;
    // Data width of results and limits
    localparam int DW = 16;
    // Signal slots: shunt ch1, bus ch1, shunt ch2, ...
    localparam int NSIG = 6;
    localparam int NCH = 3;
    // Mode field bits
    localparam int MODE_SHUNT_BIT = 0;
    localparam int MODE_BUS_BIT = 1;
    localparam int MODE_CONT_BIT = 2;
    // Reset values: continuous shunt and bus, all channels on
    localparam logic [2:0] MODE_RST = 3'h7;
    localparam logic [2:0] CHEN_RST = 3'h7;
    localparam logic [2:0] WEIGHT_RST = 3'h0;
    localparam logic [2:0] CT_RST = 3'h4;
    // Conversion times per setting, ns (140 us up to 8.244 ms)
    localparam int CT_NS [8] = '{140000, 204000, 332000, 588000,
        1100000, 2116000, 4156000, 8244000};
    // Conversion counts in cycles
    localparam int CTW = 21;
    localparam logic [CTW-1:0] CT_CYC [8] = '{
        CTW'(CT_NS[0] / CLK_NS), CTW'(CT_NS[1] / CLK_NS),
        CTW'(CT_NS[2] / CLK_NS), CTW'(CT_NS[3] / CLK_NS),
        CTW'(CT_NS[4] / CLK_NS), CTW'(CT_NS[5] / CLK_NS),
        CTW'(CT_NS[6] / CLK_NS), CTW'(CT_NS[7] / CLK_NS)};
    // Averaging divisor as a right shift per weight setting
    localparam logic [3:0] AVG_SHIFT [8] = '{4'h0, 4'h2, 4'h4,
        4'h6, 4'h7, 4'h8, 4'h9, 4'hA};
    // Sequencer states
    typedef enum logic [0:0] {st_idle, st_conv} seq_state_e;
endpackage

/* bench/adc_model.sv */
// Behavioural converter front end for the rail sequencer bench.
// Assumes conv_sig and conv_active come straight from the sequencer.
`timescale 1ns/1ps
module adc_model (
    // Clock
    input wire logic sys_clk,
    // Sequencer side
    input wire logic conv_active,
    input wire logic [2:0] conv_sig,
    // Bench side: base level for slot 0
    input wire logic signed [15:0] level,
    // Sample
    output logic signed [15:0] adc_sample
);
    logic signed [15:0] last_ff;
    logic signed [15:0] nxt_last;
    logic signed [15:0] drive;

    // Each slot reads level plus its slot number in the high byte
    always_comb begin
        drive = level + {5'h00, conv_sig, 8'h00};
    end

    // Outside a conversion the line toggles rather than hold a value
    assign adc_sample = conv_active ? drive : ~last_ff;

    // Last value on the line
    always_comb begin
        nxt_last = adc_sample;
    end

    // Register of the last value
    always_ff @(posedge sys_clk) begin
        last_ff <= nxt_last;
    end
endmodule

/* bench/tb.sv */
// Self-checking bench for the rail sequencer with short conversions.
// Assumes the adc_model partner and the seq_pkg constants.
`timescale 1ns/1ps
module tb;
    import seq_pkg::*;
    localparam logic [CTW-1:0] CTS [8] = '{21'h2, 21'h3, 21'h4, 21'h5,
        21'h6, 21'h7, 21'h8, 21'h9};
    typedef struct {logic [2:0] en, mode, cts, ctb, w;
        logic [15:0] lvl;} row_s;
    // Ordinary cases: enables, mode, shunt time, bus time, weight, level
    row_s rows [8] = '{
        '{3'h7, 3'h7, 3'h0, 3'h7, 3'h0, 16'h0100},
        '{3'h7, 3'h5, 3'h2, 3'h5, 3'h1, 16'h0800},
        '{3'h2, 3'h6, 3'h1, 3'h3, 3'h2, 16'hF000},
        '{3'h5, 3'h7, 3'h1, 3'h2, 3'h3, 16'h2000},
        '{3'h1, 3'h5, 3'h6, 3'h0, 3'h4, 16'hE000},
        '{3'h6, 3'h7, 3'h3, 3'h4, 3'h5, 16'h1000},
        '{3'h3, 3'h6, 3'h7, 3'h2, 3'h6, 16'hF800},
        '{3'h7, 3'h7, 3'h5, 3'h1, 3'h7, 16'h0400}};
    logic sys_clk, arst_n, clk_en, cfg_wr;
    logic [2:0] en, mode, cts, ctb, w, conv_sig, crit_flag, warn_flag;
    logic signed [2:0][DW-1:0] crit_limit, warn_limit;
    logic signed [DW-1:0] adc_sample, level;
    logic conv_start, conv_active, seq_ready;
    logic [5:0][DW-1:0] result;
    logic signed [DW-1:0] exp_res [6];
    int miscompares, compares, cycles, prev, sum, o;

    rail_sequencer #(.ct_cycles(CTS)) dut (.sys_clk(sys_clk),
        .arst_n(arst_n), .clk_en(clk_en), .cfg_wr(cfg_wr),
        .first_channel_enable(en[0]), .second_channel_enable(en[1]),
        .third_channel_enable(en[2]), .conversion_select_field(mode),
        .sample_weight_field(w), .shunt_conversion_time_field(cts),
        .bus_conversion_time_field(ctb), .crit_limit(crit_limit),
        .warn_limit(warn_limit), .adc_sample(adc_sample),
        .conv_start(conv_start), .conv_active(conv_active),
        .conv_sig(conv_sig), .result(result), .crit_flag(crit_flag),
        .warn_flag(warn_flag), .seq_ready(seq_ready));
    adc_model sense (.sys_clk(sys_clk), .conv_active(conv_active),
        .conv_sig(conv_sig), .level(level), .adc_sample(adc_sample));

    // Clock
    initial begin
        sys_clk = 0;
        forever #4 sys_clk = ~sys_clk;
    end

    // Hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            complete_run();
        end
    end

    // Slot is selected by its channel enable and its mode bit
    function automatic bit on(int s);
        return en[s / 2] && mode[s % 2];
    endfunction

    // Next selected slot after s in linear order with wrap
    function automatic int nxt(int s);
        for (int k = 1; k <= 6; k++)
            if (on((s + k) % 6)) return (s + k) % 6;
        return s;
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want) begin
            miscompares++;
            $display("mismatch at %0t: seen %0h want %0h", $time, seen, want);
        end
    endtask

    // Fold the finished conversion into the expected output register
    task automatic fin();
        int r;
        o = exp_res[prev];
        r = level + prev * 256;
        exp_res[prev] = 16'(o + ((r - o) >>> AVG_SHIFT[w]));
        chk(result[prev], exp_res[prev][15:0]);
    endtask

    // Follow n conversion starts, checking order, spacing and results
    task automatic obs(input int n);
        int g;
        sum = 0;
        repeat (n) begin
            g = 0;
            do begin
                @(posedge sys_clk);
                #1;
                g++;
            end while (conv_start !== 1'b1 && g < 100);
            if (prev < 0) begin
                chk(conv_sig, nxt(5));
            end else begin
                chk(g, CTS[(prev % 2) ? ctb : cts]);
                chk(conv_sig, nxt(prev));
                fin();
                sum += g;
            end
            prev = conv_sig;
        end
    endtask

    // Write a configuration; the running conversion is dropped
    task automatic cfg(input logic [2:0] e, m, s, b, v);
        en = e;
        mode = m;
        cts = s;
        ctb = b;
        w = v;
        cfg_wr = 1;
        @(posedge sys_clk);
        #1;
        cfg_wr = 0;
        prev = -1;
    endtask

    task automatic complete_run();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Main sequence
    initial begin
        arst_n = 0;
        clk_en = 1;
        cfg_wr = 0;
        {en, mode, cts, ctb, w} = {3'h7, 3'h7, 3'h4, 3'h4, 3'h0};
        level = 16'h0300;
        crit_limit = {3{16'h7FFF}};
        warn_limit = {3{16'h7FFF}};
        prev = -1;
        foreach (exp_res[i]) exp_res[i] = 16'h0000;
        repeat (3) @(posedge sys_clk);
        #1;
        chk({conv_active, conv_start, |result}, 0);
        arst_n = 1;
        obs(7);
        chk(sum, 3 * (CTS[4] + CTS[4]));
        foreach (rows[i]) begin
            level = rows[i].lvl;
            cfg(rows[i].en, rows[i].mode, rows[i].cts, rows[i].ctb,
                rows[i].w);
            obs(8);
            for (int s = 0; s < 6; s++) begin
                chk(result[s], exp_res[s][15:0]);
            end
        end
        // Raw shunt above the limit while the average sits at it
        level = 16'h3000;
        o = exp_res[0];
        o = o + ((32'sh3000 - o) >>> AVG_SHIFT[1]);
        crit_limit[0] = 16'(o);
        warn_limit[0] = 16'(o);
        cfg(3'h1, 3'h5, 3'h0, 3'h0, 3'h1);
        obs(2);
        chk(crit_flag, 3'h1);
        chk(warn_flag, 3'h0);
        // One pass over all six slots, then idle
        cfg(3'h7, 3'h3, 3'h0, 3'h0, 3'h0);
        obs(6);
        repeat (12) @(posedge sys_clk);
        #1;
        fin();
        chk({conv_active, seq_ready}, 2'h1);
        // No signal selected: the sequencer stays idle
        cfg(3'h7, 3'h4, 3'h0, 3'h0, 3'h0);
        repeat (4) @(posedge sys_clk);
        #1;
        chk({conv_active, seq_ready}, 2'h0);
        // Low clock enable freezes the start, then one signal runs
        cfg(3'h1, 3'h5, 3'h0, 3'h0, 3'h0);
        clk_en = 0;
        repeat (4) @(posedge sys_clk);
        #1;
        chk({conv_active, conv_start}, 2'h0);
        clk_en = 1;
        obs(2);
        complete_run();
    end
endmodule
